/* File: hw/cwl_regs.svh */
/*
 cwl_regs.svh: register offsets, field positions, reset values and
 widths of the codeword link receiver.
 assumes it is included by bare name from the package and design files.
*/
// What this block does
// - 32 port bits, direction chosen per byte
// - differential mode keeps bits 31..16 as inputs
// - port standard selectable, differential or single-ended
// - only the master drives strobe, valid, codeword
// - slot rate 50 MHz or whole divisions
// - back-to-back codewords are all accepted
// - link is receive-only on this instrument
// - port output latch plays no part
// - codeword width partly set by the user
// - strobe and valid bits picked by index
// - codeword taken by mask and shift, ten bits
`ifndef CWL_REGS_SVH
`define CWL_REGS_SVH
`define CWL_IDX_W 10
`define CWL_PORT_W 32
`define CWL_OFS_CTRL 5'h00
`define CWL_OFS_DOUT 5'h04
`define CWL_OFS_DIN 5'h08
`define CWL_OFS_SEL 5'h0c
`define CWL_OFS_MASK 5'h10
`define CWL_OFS_SHIFT 5'h14
`define CWL_OFS_STAT 5'h18
`define CWL_OFS_CNT 5'h1c
`define CWL_CTRL_DIFF 0
`define CWL_CTRL_LINK_EN 1
`define CWL_CTRL_OE_LSB 4
`define CWL_SEL_STRB_LSB 0
`define CWL_SEL_VLD_LSB 8
`define CWL_STAT_NEW 16
`define CWL_STAT_OVR 17
`define CWL_RST_STRB_IDX 5'h1f
`define CWL_RST_VLD_IDX 5'h1e
`define CWL_RST_MASK 32'h000003ff
`define CWL_RST_SHIFT 5'h00
`define CWL_LRST_CYC 5'h1f
`endif

/* File: hw/cwl_pkg.sv */
/*
 cwl_pkg: types and the index extraction shared by the receiver files.
 assumes cwl_regs.svh is on the include path.
*/
`include "cwl_regs.svh"
`default_nettype none
package cwl_pkg;
    typedef logic [`CWL_IDX_W-1:0] cwl_idx_t;
    typedef struct packed {
        logic link_en;
        logic [4:0] strb_idx;
        logic [4:0] vld_idx;
        logic [`CWL_PORT_W-1:0] mask;
        logic [4:0] shift;
    } cwl_cfg_s;
    typedef struct packed {
        logic tgl;
        cwl_idx_t idx;
    } cwl_word_s;
    typedef enum logic {CWL_BUS_IDLE, CWL_BUS_ACK} cwl_bus_e;
    function automatic cwl_idx_t cwl_extract(input logic [`CWL_PORT_W-1:0] port,
        input logic [`CWL_PORT_W-1:0] mask, input logic [4:0] shift);
        logic [`CWL_PORT_W-1:0] sh;
        sh = (port & mask) >> shift;
        return sh[`CWL_IDX_W-1:0];
    endfunction
endpackage
`default_nettype wire

/* File: hw/cwl_sync.sv */
/*
 cwl_sync: two flip-flop level synchroniser of parameter width.
 assumes the source is quasi-static; multi-bit words must settle
 before they are used, since bits may land one cycle apart.
*/
`default_nettype none
module cwl_sync #(
    parameter int W = 1
) (
    // clock
    input wire logic clk_i,
    // data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    always_ff @(posedge clk_i)
    begin
        meta_q <= d_i;
        sync_q <= meta_q;
    end
    assign q_o = sync_q;
endmodule // cwl_sync
`default_nettype wire

/* File: hw/cwl_link_rx.sv */
/*
 cwl_link_rx: link-side capture of codewords on the port clock.
 assumes the port clock runs freely and oversamples the strobe;
 configuration only changes while the link is disabled.
*/
`include "cwl_regs.svh"
`default_nettype none
module cwl_link_rx (
    // link clock and system reset level
    input wire logic clk_link_i,
    input wire logic rst_i,
    // configuration from the system domain
    input wire cwl_pkg::cwl_cfg_s cfg_i,
    // raw port pins
    input wire logic [`CWL_PORT_W-1:0] port_i,
    // captured word toward the system domain
    output var cwl_pkg::cwl_word_s word_o
);
    logic rst_s;
    logic [`CWL_PORT_W-1:0] port_s;
    cwl_pkg::cwl_cfg_s cfg_s;
    logic strb_q;
    logic primed_q;
    cwl_pkg::cwl_word_s word_q;
    logic strb;
    logic vld;
    logic strb_edge;

    cwl_sync #(.W(1)) u_rst_sync (.clk_i(clk_link_i), .d_i(rst_i), .q_o(rst_s));
    cwl_sync #(.W(`CWL_PORT_W)) u_port_sync (.clk_i(clk_link_i), .d_i(port_i), .q_o(port_s));
    cwl_sync #(.W($bits(cwl_pkg::cwl_cfg_s))) u_cfg_sync (
        .clk_i(clk_link_i), .d_i(cfg_i), .q_o(cfg_s));

    assign strb = port_s[cfg_s.strb_idx];
    assign vld = port_s[cfg_s.vld_idx];
    // both strobe edges open a slot, so a 25 MHz strobe gives 50 MHz slots
    assign strb_edge = primed_q && (strb != strb_q);

    always_ff @(posedge clk_link_i)
    begin
        if (rst_s)
        begin
            strb_q <= 1'b0;
            primed_q <= 1'b0;
        end
        else
        begin
            strb_q <= strb;
            primed_q <= cfg_s.link_en;
        end
    end

    always_ff @(posedge clk_link_i)
    begin
        if (rst_s)
            word_q <= '0;
        else if (cfg_s.link_en && strb_edge && vld)
        begin
            word_q.tgl <= ~word_q.tgl;
            word_q.idx <= cwl_pkg::cwl_extract(port_s, cfg_s.mask, cfg_s.shift);
        end
    end
    assign word_o = word_q;

    a_capture_word: assert property (@(posedge clk_link_i) disable iff (rst_s)
        (cfg_s.link_en && strb_edge && vld) |=> (word_q.idx ==
        cwl_pkg::cwl_extract($past(port_s), $past(cfg_s.mask), $past(cfg_s.shift))))
        else $error("captured index does not match masked port");
    a_hold_idle: assert property (@(posedge clk_link_i) disable iff (rst_s)
        !(cfg_s.link_en && strb_edge && vld) |=> $stable(word_q))
        else $error("word changed without a valid strobe edge");
    a_toggle_each: assert property (@(posedge clk_link_i) disable iff (rst_s)
        (cfg_s.link_en && strb_edge && vld) |=> (word_q.tgl != $past(word_q.tgl)))
        else $error("accepted word not flagged to the system side");
endmodule // cwl_link_rx
`default_nettype wire

/* File: hw/cwl_rx.sv */
/*
 cwl_rx: codeword link receiver with the 32-bit general port, its
 byte-wise direction control and a classic Wishbone register slave.
 assumes clk_i is the system clock, clk_link_i the free-running port
 clock input, and the port pins are resolved outside from oe.
*/
// Implementation choices: the register offsets and the Wishbone register port.
`include "cwl_regs.svh"
`default_nettype none
module cwl_rx (
    // system clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic [31:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // port clock input and general port bits
    input wire logic clk_link_i,
    input wire logic [`CWL_PORT_W-1:0] port_in_i,
    output logic [`CWL_PORT_W-1:0] port_out_o,
    output logic [`CWL_PORT_W-1:0] port_oe_o,
    // play request toward the waveform sequencer
    output logic [`CWL_IDX_W-1:0] play_idx_o,
    output logic play_stb_o
);
    // register state
    logic diff_q;
    logic link_en_q;
    logic [3:0] byte_out_q;
    logic [31:0] dout_q;
    logic [4:0] strb_idx_q;
    logic [4:0] vld_idx_q;
    logic [31:0] mask_q;
    logic [4:0] shift_q;
    logic stat_new_q;
    logic stat_ovr_q;
    logic [31:0] cnt_q;
    logic [31:0] oe_q;
    logic [31:0] oe_d;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic [`CWL_IDX_W-1:0] idx_q;
    logic play_stb_q;
    cwl_pkg::cwl_bus_e bus_q;

    // bus decode
    logic req;
    logic hit;
    logic wr;
    logic [4:0] ofs;
    logic [31:0] din_s;

    // link crossing
    cwl_pkg::cwl_cfg_s cfg;
    cwl_pkg::cwl_word_s word;
    logic tgl_s;
    logic tgl_q;
    logic new_w;
    logic [4:0] lrst_cnt_q;
    logic lrst_q;

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
                r[8*b +: 8] = nw[8*b +: 8];
        end
        return r;
    endfunction

    function automatic logic wr_hit(input logic w, input logic [4:0] at,
        input logic [4:0] want);
        return w && (at == want);
    endfunction

    // port directions: per-byte choice, differential keeps top half in
    function automatic logic [31:0] port_dir(input logic diff,
        input logic [3:0] bytes);
        logic [31:0] r;
        r = '0;
        for (int b = 0; b < 4; b++)
        begin
            if (bytes[b] && !(diff && b >= 2))
                r[8*b +: 8] = 8'hff;
        end
        return r;
    endfunction

    assign req = cyc_i && stb_i && (bus_q == cwl_pkg::CWL_BUS_IDLE);
    assign ofs = adr_i[4:0];
    assign hit = (adr_i[31:5] == 27'h0000000) && (adr_i[1:0] == 2'h0);
    assign wr = req && we_i && hit;

    // one wait state: ack a cycle after the request, then drop it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            bus_q <= cwl_pkg::CWL_BUS_IDLE;
        else
        begin
            unique case (bus_q)
                cwl_pkg::CWL_BUS_IDLE:
                    if (cyc_i && stb_i)
                        bus_q <= cwl_pkg::CWL_BUS_ACK;
                cwl_pkg::CWL_BUS_ACK:
                    bus_q <= cwl_pkg::CWL_BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            diff_q <= 1'b0;
            link_en_q <= 1'b0;
            byte_out_q <= 4'h0;
        end
        else if (wr_hit(wr, ofs, `CWL_OFS_CTRL) && sel_i[0])
        begin
            diff_q <= dat_i[`CWL_CTRL_DIFF];
            link_en_q <= dat_i[`CWL_CTRL_LINK_EN];
            byte_out_q <= dat_i[`CWL_CTRL_OE_LSB +: 4];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dout_q <= 32'h00000000;
        else if (wr_hit(wr, ofs, `CWL_OFS_DOUT))
            dout_q <= merge(dout_q, dat_i, sel_i);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            strb_idx_q <= `CWL_RST_STRB_IDX;
            vld_idx_q <= `CWL_RST_VLD_IDX;
        end
        else if (wr_hit(wr, ofs, `CWL_OFS_SEL))
        begin
            if (sel_i[0])
                strb_idx_q <= dat_i[`CWL_SEL_STRB_LSB +: 5];
            if (sel_i[1])
                vld_idx_q <= dat_i[`CWL_SEL_VLD_LSB +: 5];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mask_q <= `CWL_RST_MASK;
            shift_q <= `CWL_RST_SHIFT;
        end
        else
        begin
            if (wr_hit(wr, ofs, `CWL_OFS_MASK))
                mask_q <= merge(mask_q, dat_i, sel_i);
            if (wr_hit(wr, ofs, `CWL_OFS_SHIFT) && sel_i[0])
                shift_q <= dat_i[4:0];
        end
    end

    // config crosses as a quasi-static level; change it with the link off
    assign cfg = '{link_en: link_en_q, strb_idx: strb_idx_q, vld_idx: vld_idx_q,
                   mask: mask_q, shift: shift_q};

    // link clock is slower: a short reset pulse could fall between its
    // edges, so the link side gets a stretched reset of its own
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            lrst_cnt_q <= `CWL_LRST_CYC;
        else if (lrst_cnt_q != 5'h00)
            lrst_cnt_q <= lrst_cnt_q - 5'h01;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            lrst_q <= 1'b1;
        else
            lrst_q <= (lrst_cnt_q != 5'h00);
    end

    cwl_link_rx u_link (
        .clk_link_i(clk_link_i),
        .rst_i(lrst_q),
        .cfg_i(cfg),
        .port_i(port_in_i),
        .word_o(word)
    );

    // toggle crossing; the index is stable long before the toggle lands
    cwl_sync #(.W(1)) u_tgl_sync (.clk_i(clk_i), .d_i(word.tgl), .q_o(tgl_s));
    cwl_sync #(.W(`CWL_PORT_W)) u_din_sync (.clk_i(clk_i), .d_i(port_in_i), .q_o(din_s));

    // toggle is unknown until the stretched reset has surely reached the link side
    assign new_w = !lrst_q && (tgl_s ^ tgl_q);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            tgl_q <= 1'b0;
        else
            tgl_q <= tgl_s;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            idx_q <= '0;
            play_stb_q <= 1'b0;
        end
        else
        begin
            play_stb_q <= new_w;
            if (new_w)
                idx_q <= word.idx;
        end
    end

    // set beats a simultaneous write-one clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stat_new_q <= 1'b0;
            stat_ovr_q <= 1'b0;
        end
        else
        begin
            if (new_w)
                stat_new_q <= 1'b1;
            else if (wr_hit(wr, ofs, `CWL_OFS_STAT) && sel_i[2] && dat_i[`CWL_STAT_NEW])
                stat_new_q <= 1'b0;
            if (new_w && stat_new_q)
                stat_ovr_q <= 1'b1;
            else if (wr_hit(wr, ofs, `CWL_OFS_STAT) && sel_i[2] && dat_i[`CWL_STAT_OVR])
                stat_ovr_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt_q <= 32'h00000000;
        else if (new_w)
            cnt_q <= cnt_q + 32'h00000001;
        else if (wr_hit(wr, ofs, `CWL_OFS_CNT))
            cnt_q <= 32'h00000000;
    end

    // link lines are not driven back while the link is enabled: receive-only, no output latch
    always_comb
    begin
        oe_d = port_dir(diff_q, byte_out_q);
        if (link_en_q)
        begin
            oe_d[strb_idx_q] = 1'b0;
            oe_d[vld_idx_q] = 1'b0;
            oe_d = oe_d & ~mask_q;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            oe_q <= 32'h00000000;
        else
            oe_q <= oe_d;
    end

    always_comb
    begin
        rdata_d = 32'h00000000;
        if (hit)
        begin
            unique case (ofs)
                `CWL_OFS_CTRL: rdata_d = {24'h000000, byte_out_q, 2'h0, link_en_q, diff_q};
                `CWL_OFS_DOUT: rdata_d = dout_q;
                `CWL_OFS_DIN: rdata_d = din_s;
                `CWL_OFS_SEL: rdata_d = {19'h00000, vld_idx_q, 3'h0, strb_idx_q};
                `CWL_OFS_MASK: rdata_d = mask_q;
                `CWL_OFS_SHIFT: rdata_d = {27'h0000000, shift_q};
                `CWL_OFS_STAT: rdata_d = {14'h0000, stat_ovr_q, stat_new_q, 6'h00, idx_q};
                `CWL_OFS_CNT: rdata_d = cnt_q;
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_q <= 32'h00000000;
        else if (req && !we_i)
            rdata_q <= rdata_d;
    end

    assign dat_o = rdata_q;
    assign ack_o = (bus_q == cwl_pkg::CWL_BUS_ACK);
    assign port_out_o = dout_q;
    assign port_oe_o = oe_q;
    assign play_idx_o = idx_q;
    assign play_stb_o = play_stb_q;

    a_ack_timing: assert property (@(posedge clk_i) disable iff (rst_i)
        (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
        else $error("ack not given one cycle after request");
    a_diff_upper_in: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(diff_q) |-> (port_oe_o[31:16] == 16'h0000))
        else $error("upper half driven in differential mode");
    a_byte_dir: assert property (@(posedge clk_i) disable iff (rst_i)
        (!$past(diff_q) && !$past(link_en_q)) |->
        (port_oe_o[31:24] == {8{$past(byte_out_q[3])}}))
        else $error("top byte direction does not follow control");
    a_link_no_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(link_en_q) |-> !port_oe_o[$past(strb_idx_q)] && !port_oe_o[$past(vld_idx_q)])
        else $error("receiver drives a link line");
    a_play_word: assert property (@(posedge clk_i) disable iff (rst_i)
        new_w |=> play_stb_o && (play_idx_o == $past(word.idx)))
        else $error("play request missing or wrong index");
    a_new_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        new_w |=> stat_new_q)
        else $error("new word flag lost");
    a_cnt_step: assert property (@(posedge clk_i) disable iff (rst_i)
        new_w |=> (cnt_q == $past(cnt_q) + 32'h00000001))
        else $error("word count did not advance");
    a_mask_in: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(link_en_q) |-> ((port_oe_o & $past(mask_q)) == 32'h00000000))
        else $error("codeword bit driven while link enabled");
endmodule // cwl_rx
`default_nettype wire

/* File: dv/cwl_link_master.sv */
/*
 cwl_link_master: behavioural link master driving strobe, valid and
 codeword onto the port pins.
 assumes the bench resolves these pins against the receiver's enables.
*/
`default_nettype none
module cwl_link_master (
    // link clock
    input wire logic clk_link_i,
    // pins as the master drives them
    output logic [31:0] pins_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int half = 2;
    int strb = 31;
    int vld = 30;
    int lsb = 0;
    int cnt = 0; // same strobe phase after every start
    logic strobe_q = 1'b0;
    logic has = 1'b0;
    logic pv = 1'b0;
    logic [9:0] pw = 10'h000;
    logic [31:0] p;
    initial pins_o = 32'h00000000;
    // slot lasts half link clocks: 50 MHz divided by a whole number
    always @(posedge clk_link_i)
    begin
        if (cnt >= half - 1)
        begin
            cnt = 0;
            strobe_q = ~strobe_q;
            // idle codeword lines get fresh noise, never a held value
            p = $urandom;
            if (has && pv)
                p[lsb+:10] = pw;
            p[vld] = has && pv;
            p[strb] = strobe_q;
            has = 1'b0;
            pins_o <= p;
        end
        else
            cnt = cnt + 1;
    end
    task automatic send(input logic v, input logic [9:0] w);
        while (has)
            @(posedge clk_link_i);
        pv = v;
        pw = w;
        has = 1'b1;
    endtask
endmodule // cwl_link_master
`default_nettype wire

/* File: dv/tb.sv */
/*
 tb: self-checking bench for cwl_rx with a behavioural link master.
 assumes cwl_regs.svh on the include path; pins resolved here from oe.
*/
`include "cwl_regs.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic clk_link_i = 1'b0;
    logic rst_i;
    logic [31:0] adr_i;
    logic [31:0] dat_i;
    logic [3:0] sel_i;
    logic we_i;
    logic cyc_i;
    logic stb_i;
    logic [31:0] dat_o;
    logic ack_o;
    logic [31:0] port_in_i;
    logic [31:0] port_out_o;
    logic [31:0] port_oe_o;
    logic [9:0] play_idx_o;
    logic play_stb_o;
    logic [31:0] mst_pins;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [31:0] exp_rd[$];
    logic [9:0] exp_play[$];
    logic [31:0] w32;
    logic [9:0] w;
    logic v;
    logic [3:0] bsel = 4'hf;
    int k;
    assign port_in_i = (port_oe_o & port_out_o) | (~port_oe_o & mst_pins);
    cwl_rx i_cwl_rx (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
        .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
        .ack_o(ack_o), .clk_link_i(clk_link_i), .port_in_i(port_in_i),
        .port_out_o(port_out_o), .port_oe_o(port_oe_o), .play_idx_o(play_idx_o),
        .play_stb_o(play_stb_o));
    cwl_link_master i_cwl_link_master (.clk_link_i(clk_link_i), .pins_o(mst_pins));
    initial forever #20 clk_i = ~clk_i;
    initial
    begin
        #13;
        forever #80 clk_link_i = ~clk_link_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("comparisons=%0d mismatches=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, d, e);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= wr;
        sel_i <= bsel;
        adr_i <= a;
        dat_i <= d;
        if (!wr)
            exp_rd.push_back(e);
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 50);
        if (n >= 50)
            n_errors++;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask
    task automatic drain();
        int n;
        n = 0;
        while (exp_play.size() != 0 && n < 300)
        begin
            @(posedge clk_i);
            n++;
        end
        chk(32'(exp_play.size()), 32'h0);
    endtask
    // results are checked where they appear, against the oldest note
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            complete_run();
        end
        if (!rst_i && ack_o === 1'b1 && cyc_i && !we_i)
            if (exp_rd.size() == 0)
                chk(32'h1, 32'h0);
            else
                chk(dat_o, exp_rd.pop_front());
        if (!rst_i && play_stb_o === 1'b1)
            if (exp_play.size() == 0)
                chk(32'h1, 32'h0);
            else
                chk({22'h0, play_idx_o}, {22'h0, exp_play.pop_front()});
    end
    initial
    begin
        rst_i = 1'b1;
        adr_i = 32'h0;
        dat_i = 32'h0;
        sel_i = 4'hf;
        we_i = 1'b0;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        void'($urandom(32'h6e0b2569));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        chk(port_oe_o, 32'h0);
        bus(1'b0, 32'(`CWL_OFS_SEL), 32'h0, 32'h00001e1f);
        bus(1'b0, 32'(`CWL_OFS_MASK), 32'h0, 32'h000003ff);
        bus(1'b0, 32'(`CWL_OFS_SHIFT), 32'h0, 32'h0);
        bus(1'b0, 32'(`CWL_OFS_CTRL), 32'h0, 32'h0);
        bus(1'b1, 32'h00000020, 32'hffffffff, 32'h0);
        bus(1'b0, 32'h00000020, 32'h0, 32'h0);
        bsel = 4'h2;
        bus(1'b1, 32'(`CWL_OFS_MASK), 32'hffffffff, 32'h0);
        bsel = 4'hf;
        bus(1'b0, 32'(`CWL_OFS_MASK), 32'h0, 32'h0000ffff);
        bus(1'b1, 32'(`CWL_OFS_MASK), 32'h000003ff, 32'h0);
        $display("test registers done");
        for (int d = 0; d < 2; d++)
            for (int b = 0; b < 4; b++)
            begin
                bus(1'b1, 32'(`CWL_OFS_CTRL), (32'h10 << b) | 32'(d), 32'h0);
                repeat (2) @(posedge clk_i);
                chk(port_oe_o, (d == 1 && b > 1) ? 32'h0 : 32'hff << (8 * b));
            end
        w32 = $urandom;
        bus(1'b1, 32'(`CWL_OFS_CTRL), 32'h000000f0, 32'h0);
        bus(1'b1, 32'(`CWL_OFS_DOUT), w32, 32'h0);
        repeat (2) @(posedge clk_i);
        chk(port_out_o, w32);
        repeat (4) @(posedge clk_i);
        bus(1'b0, 32'(`CWL_OFS_DIN), 32'h0, w32);
        $display("test direction done");
        bus(1'b1, 32'(`CWL_OFS_CTRL), 32'h00000002, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            w = 10'($urandom);
            exp_play.push_back(w);
            i_cwl_link_master.send(1'b1, w);
        end
        drain();
        bus(1'b0, 32'(`CWL_OFS_CNT), 32'h0, 32'h6);
        bus(1'b0, 32'(`CWL_OFS_STAT), 32'h0, 32'h00030000 | 32'(w));
        bsel = 4'hb;
        bus(1'b1, 32'(`CWL_OFS_STAT), 32'h00030000, 32'h0);
        bsel = 4'hf;
        bus(1'b0, 32'(`CWL_OFS_STAT), 32'h0, 32'h00030000 | 32'(w));
        bus(1'b1, 32'(`CWL_OFS_STAT), 32'h00030000, 32'h0);
        bus(1'b0, 32'(`CWL_OFS_STAT), 32'h0, 32'(w));
        $display("test back to back done");
        bus(1'b1, 32'(`CWL_OFS_CTRL), 32'h0, 32'h0);
        bus(1'b1, 32'(`CWL_OFS_SEL), 32'h00001514, 32'h0);
        bus(1'b1, 32'(`CWL_OFS_MASK), 32'h00003f00, 32'h0);
        bus(1'b1, 32'(`CWL_OFS_SHIFT), 32'h4, 32'h0);
        bus(1'b1, 32'(`CWL_OFS_CNT), 32'h0, 32'h0);
        i_cwl_link_master.strb = 20;
        i_cwl_link_master.vld = 21;
        i_cwl_link_master.lsb = 4;
        i_cwl_link_master.half = 4;
        bus(1'b1, 32'(`CWL_OFS_CTRL), 32'h000000f2, 32'h0);
        repeat (2) @(posedge clk_i);
        chk(port_oe_o, ~32'h00303f00);
        k = 0;
        for (int i = 0; i < 9; i++)
        begin
            v = (i % 3) != 1;
            w = 10'($urandom);
            if (v)
            begin
                exp_play.push_back(w & 10'h3f0);
                k++;
            end
            i_cwl_link_master.send(v, w);
        end
        drain();
        bus(1'b0, 32'(`CWL_OFS_CNT), 32'h0, 32'(k));
        $display("test mask and shift done");
        bus(1'b1, 32'(`CWL_OFS_CTRL), 32'h0, 32'h0);
        for (int i = 0; i < 4; i++)
            i_cwl_link_master.send(1'b1, 10'($urandom));
        repeat (60) @(posedge clk_i);
        bus(1'b0, 32'(`CWL_OFS_CNT), 32'h0, 32'(k));
        $display("test link disabled done");
        complete_run();
    end
endmodule // tb
`default_nettype wire
